// >>> hw/rbms_defines.vh
// constants for the reset and boot mode sampler
`ifndef RBMS_DEFINES_VH
`define RBMS_DEFINES_VH

// register byte offsets
`define RBMS_CTRL_OFF        12'h000
`define RBMS_STATUS_OFF      12'h004
`define RBMS_ID_OFF          12'h008
`define RBMS_ADDR_W          12

// control register fields
`define RBMS_CTRL_PORT_B_LINE_18_VAL   0
`define RBMS_CTRL_PORT_B_LINE_18_DRV   1
`define RBMS_CTRL_SER_EN     2
`define RBMS_CTRL_SHR_VAL    3
`define RBMS_CTRL_SHR_DRV    4
`define RBMS_CTRL_W          5
`define RBMS_CTRL_RST        5'h00

// status register fields
`define RBMS_ST_BOOT_LVL     0
`define RBMS_ST_FLOAT        1
`define RBMS_ST_DBG_BSCAN    2
`define RBMS_ST_BOOT_MIXED   3
`define RBMS_ST_SHORT_RST    4
`define RBMS_ST_WDT_CAUSE    5
`define RBMS_ST_PORT_B_LINE_18_IN      6
`define RBMS_ST_SHR_IN       7

// mode reset values (before the first external reset release)
`define RBMS_BOOT_RST        1'b0
`define RBMS_FLOAT_RST       1'b0

// timing counts, in master clock cycles
`define RBMS_SAMPLE_CYC      10
`define RBMS_WDT_HOLD_CYC    16
`define RBMS_CNT_W           5

// boundary scan instruction codes
`define RBMS_IR_W            4
`define RBMS_IR_EXTEST       4'h0
`define RBMS_IR_SAMPLE       4'h1
`define RBMS_IR_BYPASS       4'hF

// fixed restart address of the processor
`define RBMS_RESET_VECTOR    32'h00000000

`endif

// >>> hw/rbms_reset_sync.v
// reset synchroniser: asynchronous entry, release aligned to the clock
`timescale 1ns/1ps
module rbms_reset_sync #(
    parameter STAGES = 2
) (
    // clock and raw reset
    input  wire clk,
    input  wire arst_n,
    // synchronised reset
    output wire rst_n_out
);
    reg [STAGES-1:0] chain_reg;

    // ones shift in after release; a low raw reset clears the chain at once
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_reg <= {STAGES{1'b0}};
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], 1'b1};
        end
    end

    assign rst_n_out = chain_reg[STAGES-1];
endmodule

// >>> hw/rbms_sync2.v
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module rbms_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // asynchronous levels in, synchronised levels out
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // first stage feeds only the second
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// >>> hw/rbms_reset_boot_sampler.v
// chip reset, boot mode and tristate sampling, debug port selection
//
// Overview of operation
// - reset enters asynchronously on the pin, leaves in step with the master clock
// - boot and float selects sampled over the last ten cycles before release
// - the external reset pin never touches the emulation debug logic
// - watchdog reset acts as the pin but keeps the latched modes
// - external reset wins over a coinciding watchdog reset, sampling included
// - reset restores peripheral registers and restarts fetch at address zero
// - external bus address lines are driven low throughout reset
// - peripheral clocks are gated off while reset is active
// - boot select low: 16-bit chip select 0; high: 8-bit or internal 32-bit memory
// - after reset the boot select pin is port B line 18 general I/O
// - float mode keeps running but releases every output driver
// - float mode needs the select low all ten cycles; board holds it high otherwise
// - float select pin shares general I/O and serial channel 1 transmit
// - debug port goes to emulation when select low, boundary scan when high
// - emulation debug logic has its own reset input
// - boundary scan mode decodes sample, extest and bypass
// - emulation mode returns a core identification, not the scan one
`timescale 1ns/1ps
`include "rbms_defines.vh"
module rbms_reset_boot_sampler #(
    parameter        HAS_NVM     = 0,
    parameter        PAD_W       = 32,
    parameter        CLKEN_W     = 16,
    parameter [31:0] CORE_ID     = 32'h1234_5678,  // arbitrary value
    parameter [31:0] SCAN_ID     = 32'h0ABC_DEF1,  // arbitrary value
    parameter [4:0]  WDT_HOLD    = `RBMS_WDT_HOLD_CYC
) (
    // clock and power-on reset
    input  wire                   clk,
    input  wire                   rst_b,
    // reset sources
    input  wire                   hw_reset_in_n,
    input  wire                   wdt_reset_req,
    // generated resets and restart address
    output wire                   core_reset_n,
    output wire                   periph_reset_n,
    output wire [31:0]            reset_vector,
    // boot memory selection
    output reg                    boot_internal_nvm,
    output reg                    boot_ext_16bit,
    output reg                    boot_chip_select_en,
    // boot select pin, later port B line 18
    input  wire                   boot_select_pin,
    output reg                    port_b_line_18_out,
    output reg                    port_b_line_18_oe_n,
    // float select pin, shared with general I/O and serial transmit
    input  wire                   float_outputs_select_n,
    input  wire                   serial1_transmit,
    output reg                    shared_io_line_out,
    output reg                    shared_io_line_oe_n,
    // external bus address, clock enables and pad drivers
    input  wire [23:0]            ebi_addr_in,
    output reg  [23:0]            ebi_addr_out,
    input  wire [CLKEN_W-1:0]     periph_clk_en_in,
    output reg  [CLKEN_W-1:0]     periph_clk_en_out,
    input  wire [PAD_W-1:0]       pad_oe_n_in,
    output reg  [PAD_W-1:0]       pad_oe_n_out,
    // debug port
    input  wire                   debug_port_select,
    input  wire                   debug_logic_reset_n,
    input  wire [`RBMS_IR_W-1:0]  bscan_ir,
    output wire                   ice_enable,
    output wire                   bscan_enable,
    output wire                   ice_reset_n,
    output wire                   bscan_extest,
    output wire                   bscan_sample,
    output wire                   bscan_bypass,
    output wire [31:0]            chip_id,
    // apb slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`RBMS_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output wire                   pready,
    output wire                   pslverr,
    output reg  [31:0]            prdata
);
    wire       ext_rst_n;
    wire       dbg_rst_n;
    wire [2:0] pins_s;
    wire       boot_s;
    wire       float_s;
    wire       dbgsel_s;

    reg        ext_rst_d_reg;
    reg [`RBMS_SAMPLE_CYC-1:0] boot_hist_reg;
    reg [`RBMS_SAMPLE_CYC-1:0] float_hist_reg;
    reg [`RBMS_CNT_W-1:0]      rst_cnt_reg;
    reg        boot_lvl_reg;
    reg        float_mode_reg;
    reg        boot_mixed_reg;
    reg        short_rst_reg;
    reg        wdt_cause_reg;
    reg [`RBMS_CNT_W-1:0]      wdt_cnt_reg;
    reg        sys_rst_n_reg;
    reg        dbg_bscan_reg;
    reg [`RBMS_CTRL_W-1:0]     ctrl_reg;

    // external reset plus power-on reset, released after two clock edges
    rbms_reset_sync #(
        .STAGES (2)
    ) u_ext_sync (
        .clk       (clk),
        .arst_n    (rst_b & hw_reset_in_n),
        .rst_n_out (ext_rst_n)
    );

    // debug logic reset ignores the external reset pin entirely
    rbms_reset_sync #(
        .STAGES (2)
    ) u_dbg_sync (
        .clk       (clk),
        .arst_n    (rst_b & debug_logic_reset_n),
        .rst_n_out (dbg_rst_n)
    );

    // pin levels cross in before any logic looks at them; same delay as the reset
    rbms_sync2 #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({debug_port_select, float_outputs_select_n, boot_select_pin}),
        .q     (pins_s)
    );

    assign boot_s   = pins_s[0];
    assign float_s  = pins_s[1];
    assign dbgsel_s = pins_s[2];

    // watchdog hold counter; the external reset clears it so it cannot outlast it
    always @(posedge clk or negedge ext_rst_n) begin
        if (!ext_rst_n) begin
            wdt_cnt_reg <= {`RBMS_CNT_W{1'b0}};
        end else if (wdt_reset_req) begin
            wdt_cnt_reg <= WDT_HOLD;
        end else if (wdt_cnt_reg != {`RBMS_CNT_W{1'b0}}) begin
            wdt_cnt_reg <= wdt_cnt_reg - 1'b1;
        end
    end

    // system reset: low at once with the pin, also low while the watchdog holds it
    always @(posedge clk or negedge ext_rst_n) begin
        if (!ext_rst_n) begin
            sys_rst_n_reg <= 1'b0;
        end else begin
            sys_rst_n_reg <= ~wdt_reset_req & (wdt_cnt_reg == {`RBMS_CNT_W{1'b0}});
        end
    end

    assign core_reset_n   = sys_rst_n_reg;
    assign periph_reset_n = sys_rst_n_reg;
    assign reset_vector   = `RBMS_RESET_VECTOR;

    // sample history lives in the power-on domain so the external reset cannot wipe it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_rst_d_reg  <= 1'b0;
            boot_hist_reg  <= {`RBMS_SAMPLE_CYC{1'b0}};
            float_hist_reg <= {`RBMS_SAMPLE_CYC{1'b1}};
            rst_cnt_reg    <= {`RBMS_CNT_W{1'b0}};
        end else begin
            ext_rst_d_reg <= ext_rst_n;
            if (!ext_rst_n) begin
                boot_hist_reg  <= {boot_hist_reg[`RBMS_SAMPLE_CYC-2:0], boot_s};
                float_hist_reg <= {float_hist_reg[`RBMS_SAMPLE_CYC-2:0], float_s};
                if (rst_cnt_reg != `RBMS_SAMPLE_CYC) begin
                    rst_cnt_reg <= rst_cnt_reg + 1'b1;
                end
            end else begin
                rst_cnt_reg <= {`RBMS_CNT_W{1'b0}};
            end
        end
    end

    // latch modes on the external release only; watchdog release leaves them alone
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_lvl_reg   <= `RBMS_BOOT_RST;
            float_mode_reg <= `RBMS_FLOAT_RST;
            boot_mixed_reg <= 1'b0;
            short_rst_reg  <= 1'b0;
        end else if (ext_rst_n && !ext_rst_d_reg) begin
            boot_lvl_reg   <= boot_hist_reg[0];
            float_mode_reg <= (float_hist_reg == {`RBMS_SAMPLE_CYC{1'b0}});
            boot_mixed_reg <= (boot_hist_reg != {`RBMS_SAMPLE_CYC{1'b0}}) &&
                              (boot_hist_reg != {`RBMS_SAMPLE_CYC{1'b1}});
            short_rst_reg  <= (rst_cnt_reg != `RBMS_SAMPLE_CYC);
        end
    end

    // reset cause: set by a watchdog reset, cleared by the external one
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cause_reg <= 1'b0;
        end else if (!ext_rst_n) begin
            wdt_cause_reg <= 1'b0;
        end else if (wdt_reset_req) begin
            wdt_cause_reg <= 1'b1;
        end
    end

    // boot memory decode from the latched level
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_internal_nvm   <= 1'b0;
            boot_ext_16bit      <= 1'b0;
            boot_chip_select_en <= 1'b0;
        end else begin
            boot_internal_nvm   <= boot_lvl_reg && (HAS_NVM != 0);
            boot_ext_16bit      <= ~boot_lvl_reg;
            boot_chip_select_en <= ~(boot_lvl_reg && (HAS_NVM != 0));
        end
    end

    // debug routing is taken while the debug reset is low, so a live change has no effect
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_bscan_reg <= 1'b0;
        end else if (!dbg_rst_n) begin
            dbg_bscan_reg <= dbgsel_s;
        end
    end

    assign ice_enable   = ~dbg_bscan_reg;
    assign bscan_enable = dbg_bscan_reg;
    assign ice_reset_n  = dbg_rst_n;
    assign bscan_extest = dbg_bscan_reg && (bscan_ir == `RBMS_IR_EXTEST);
    assign bscan_sample = dbg_bscan_reg && (bscan_ir == `RBMS_IR_SAMPLE);
    // unknown codes fall back to bypass, the safe choice for a scan chain
    assign bscan_bypass = dbg_bscan_reg && !bscan_extest && !bscan_sample;
    assign chip_id      = dbg_bscan_reg ? SCAN_ID : CORE_ID;

    // pin outputs: reset forces address low, clocks off and pins to input
    always @(posedge clk or negedge sys_rst_n_reg) begin
        if (!sys_rst_n_reg) begin
            ebi_addr_out        <= 24'h000000;
            periph_clk_en_out   <= {CLKEN_W{1'b0}};
            pad_oe_n_out        <= {PAD_W{1'b1}};
            port_b_line_18_out  <= 1'b0;
            port_b_line_18_oe_n <= 1'b1;
            shared_io_line_out  <= 1'b0;
            shared_io_line_oe_n <= 1'b1;
        end else begin
            ebi_addr_out       <= ebi_addr_in;
            periph_clk_en_out  <= periph_clk_en_in;
            pad_oe_n_out       <= pad_oe_n_in | {PAD_W{float_mode_reg}};
            port_b_line_18_out <= ctrl_reg[`RBMS_CTRL_PORT_B_LINE_18_VAL];
            port_b_line_18_oe_n <= ~ctrl_reg[`RBMS_CTRL_PORT_B_LINE_18_DRV] | float_mode_reg;
            shared_io_line_out <= ctrl_reg[`RBMS_CTRL_SER_EN] ? serial1_transmit :
                                  ctrl_reg[`RBMS_CTRL_SHR_VAL];
            shared_io_line_oe_n <= ~(ctrl_reg[`RBMS_CTRL_SER_EN] | ctrl_reg[`RBMS_CTRL_SHR_DRV]) |
                                   float_mode_reg;
        end
    end

    // apb: zero wait states, error on unmapped accesses and on read-only writes
    wire apb_acc     = psel & penable;
    wire hit_ctrl    = (paddr == `RBMS_CTRL_OFF);
    wire hit_status  = (paddr == `RBMS_STATUS_OFF);
    wire hit_id      = (paddr == `RBMS_ID_OFF);

    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~(hit_ctrl | ((hit_status | hit_id) & ~pwrite));

    // control register returns to defaults on every chip reset
    always @(posedge clk or negedge sys_rst_n_reg) begin
        if (!sys_rst_n_reg) begin
            ctrl_reg <= `RBMS_CTRL_RST;
        end else if (apb_acc && pwrite && hit_ctrl) begin
            ctrl_reg <= pwdata[`RBMS_CTRL_W-1:0];
        end
    end

    // read data is registered in the setup cycle so it stands in the access phase
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_ctrl) begin
                prdata <= {{(32-`RBMS_CTRL_W){1'b0}}, ctrl_reg};
            end else if (hit_status) begin
                prdata <= {24'h000000, shared_io_line_oe_n ? float_s : 1'b0,
                           port_b_line_18_oe_n ? boot_s : 1'b0,
                           wdt_cause_reg, short_rst_reg, boot_mixed_reg,
                           dbg_bscan_reg, float_mode_reg, boot_lvl_reg};
            end else if (hit_id) begin
                prdata <= chip_id;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule

// >>> test/rbms_reset_boot_sampler_monitor.sv
// assertion checker bound to the reset and boot mode sampler
`timescale 1ns/1ps
`include "rbms_defines.vh"
module rbms_reset_boot_sampler_monitor #(
    parameter        CLKEN_W = 16,
    parameter [31:0] CORE_ID = 32'h0,
    parameter [31:0] SCAN_ID = 32'h0
) (
    // clock and resets
    input logic                  clk,
    input logic                  rst_b,
    input logic                  hw_reset_in_n,
    input logic                  wdt_reset_req,
    input logic                  core_reset_n,
    input logic                  periph_reset_n,
    // boot and bus outputs
    input logic                  boot_ext_16bit,
    input logic                  boot_chip_select_en,
    input logic [23:0]           ebi_addr_out,
    input logic [CLKEN_W-1:0]    periph_clk_en_out,
    // debug port
    input logic                  debug_port_select,
    input logic                  debug_logic_reset_n,
    input logic [`RBMS_IR_W-1:0] bscan_ir,
    input logic                  ice_enable,
    input logic                  bscan_enable,
    input logic                  bscan_extest,
    input logic                  bscan_sample,
    input logic                  bscan_bypass,
    input logic [31:0]           chip_id
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // entry is immediate, exit only after the synchroniser edges
    entry_now_a: assert property (!hw_reset_in_n |-> !core_reset_n) else $error("reset entry late");
    exit_sync_a: assert property ($rose(hw_reset_in_n) |-> !core_reset_n ##1 !core_reset_n ##[1:4] core_reset_n)
        else $error("reset exit timing");
    // one cycle of slack, so a register cleared by the reset edge still passes
    addr_low_a: assert property (!periph_reset_n && !$past(periph_reset_n) |-> ebi_addr_out == '0)
        else $error("address not low in reset");
    clk_off_a: assert property (!periph_reset_n && !$past(periph_reset_n) |-> periph_clk_en_out == '0)
        else $error("clocks running in reset");
    // watchdog resets the chip but leaves the boot choice alone
    wdt_reset_a: assert property (wdt_reset_req && hw_reset_in_n && core_reset_n |=> !core_reset_n)
        else $error("watchdog reset missing");
    wdt_keep_a: assert property (wdt_reset_req && hw_reset_in_n |=>
        ($stable(boot_ext_16bit) && $stable(boot_chip_select_en)) [*8]) else $error("boot mode changed");
    scan_route_a: assert property ((!debug_logic_reset_n && debug_port_select) [*6] |->
        bscan_enable && !ice_enable) else $error("scan route");
    dbg_hold_a: assert property (debug_logic_reset_n && $past(debug_logic_reset_n, 4) |->
        $stable(bscan_enable) && $stable(ice_enable)) else $error("debug route moved");
    ir_decode_a: assert property (bscan_enable |-> bscan_extest == (bscan_ir == `RBMS_IR_EXTEST) &&
        bscan_sample == (bscan_ir == `RBMS_IR_SAMPLE) && bscan_bypass == !(bscan_extest || bscan_sample))
        else $error("scan decode");
    id_pick_a: assert property (chip_id == (bscan_enable ? SCAN_ID : CORE_ID)) else $error("chip id");
endmodule

// >>> test/rbms_board_model.sv
// board model: reset circuit, strap resistors and debug probe
`timescale 1ns/1ps
module rbms_board_model (
    // master clock
    input  logic clk,
    // pins driven by the board
    output logic hw_reset_in_n,
    output logic boot_select_pin,
    output logic float_outputs_select_n,
    output logic debug_port_select,
    output logic debug_logic_reset_n
);
    // straps at rest: float line pulled up, boot resistor low
    initial begin
        hw_reset_in_n          = 1'h0;
        boot_select_pin        = 1'h0;
        float_outputs_select_n = 1'h1;
        debug_port_select      = 1'h0;
        debug_logic_reset_n    = 1'h1;
    end
    // reset held 17 cycles with the clock running; float select low for the last flt
    task pin_reset(input logic boot, input int flt);
        hw_reset_in_n   <= 1'h0;
        boot_select_pin <= boot;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            float_outputs_select_n <= (i < 16 - flt);
        end
        @(posedge clk);
        hw_reset_in_n          <= 1'h1;
        float_outputs_select_n <= 1'h1;
    endtask
    // a new debug route is only taken under the debug reset
    task dbg_reset(input logic sel);
        debug_port_select   <= sel;
        debug_logic_reset_n <= 1'h0;
        repeat (8) @(posedge clk);
        debug_logic_reset_n <= 1'h1;
    endtask
    task strap(input logic boot);
        boot_select_pin <= boot;
    endtask
endmodule

// >>> test/rbms_reset_boot_sampler_tb.sv
// self-checking bench for the reset and boot mode sampler
`timescale 1ns/1ps
`include "rbms_defines.vh"
module rbms_reset_boot_sampler_tb;
    localparam [31:0] CID = 32'h13579BDF; // arbitrary value
    localparam [31:0] SID = 32'h2468ACE0; // arbitrary value
    logic        clk = 1'h0, rst_b = 1'h0, wdt_reset_req = 1'h0, serial1_transmit = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, pad_oe_n_in = 32'h0, rd;
    logic [23:0] ebi_addr_in = 24'hA5C35A;
    logic [15:0] periph_clk_en_in = 16'hFFFF;
    logic [3:0]  bscan_ir = 4'h0;
    logic [3:0]  ir_tab [4] = '{`RBMS_IR_EXTEST, `RBMS_IR_SAMPLE, `RBMS_IR_BYPASS, 4'h6};
    logic [2:0]  dec_tab [4] = '{3'h4, 3'h2, 3'h1, 3'h1};
    wire         hw_reset_in_n, brd_boot, brd_flt, debug_port_select, debug_logic_reset_n;
    wire         boot_select_pin, float_outputs_select_n, core_reset_n, periph_reset_n, ice_reset_n;
    wire         boot_internal_nvm, boot_ext_16bit, boot_chip_select_en, port_b_line_18_out;
    wire         port_b_line_18_oe_n, shared_io_line_out, shared_io_line_oe_n, ice_enable, bscan_enable;
    wire         bscan_extest, bscan_sample, bscan_bypass, pready, pslverr;
    wire [31:0]  reset_vector, pad_oe_n_out, chip_id, prdata;
    wire [23:0]  ebi_addr_out;
    wire [15:0]  periph_clk_en_out;
    int          mismatches, n_tests, cyc;
    // shared pins: the dut wins while it drives, else the board level
    assign boot_select_pin = port_b_line_18_oe_n ? brd_boot : port_b_line_18_out;
    assign float_outputs_select_n = shared_io_line_oe_n ? brd_flt : shared_io_line_out;
    rbms_reset_boot_sampler #(.CORE_ID(CID), .SCAN_ID(SID), .WDT_HOLD(5'h4)) dut (.*);
    rbms_board_model board (.clk(clk), .hw_reset_in_n(hw_reset_in_n), .boot_select_pin(brd_boot),
        .float_outputs_select_n(brd_flt), .debug_port_select(debug_port_select),
        .debug_logic_reset_n(debug_logic_reset_n));
    initial begin
        forever #2 clk = ~clk;
    end
    // the sequence needs under 1000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            final_report();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // setup, then access held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    // bounded wait for the chip reset to lift, plus the boot decode edge
    task wait_up();
        for (int k = 0; k < 24 && core_reset_n !== 1'h1; k++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task reset_pin(input logic boot, input int flt);
        board.pin_reset(boot, flt);
        wait_up();
    endtask
    task final_report();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        board.dbg_reset(1'h0);
        reset_pin(1'h0, 0);
        chk("boot16", 1, boot_ext_16bit);
        chk("cs0", 1, boot_chip_select_en);
        chk("nvm", 0, boot_internal_nvm);
        chk("addr", ebi_addr_in, ebi_addr_out);
        chk("clken", periph_clk_en_in, periph_clk_en_out);
        chk("ice", 1, ice_enable);
        chk("ice_rst", 1, ice_reset_n);
        chk("vector", 0, reset_vector);
        rd_chk("status", 12'h004, 32'hFF, 32'h80);
        rd_chk("id", 12'h008, 32'hFFFFFFFF, CID);
        rd_chk("gap", 12'h00C, 32'hFFFFFFFF, 32'h0);
        chk("gap_err", 1, err);
        apb(1'h1, 12'h004, 32'hFF);
        chk("ro_err", 1, err);
        apb(1'h1, 12'h000, 32'hFFFFFFFF);
        rd_chk("ctrl", 12'h000, 32'hFFFFFFFF, 32'h1F);
        apb(1'h1, 12'h000, 32'h3);
        repeat (2) @(posedge clk);
        chk("port_b_line_18", 2'h1, {port_b_line_18_oe_n, port_b_line_18_out});
        apb(1'h1, 12'h000, 32'h14);
        for (int s = 0; s < 2; s++) begin
            serial1_transmit <= s[0];
            repeat (3) @(posedge clk);
            chk("shared", s, {shared_io_line_oe_n, shared_io_line_out});
        end
        // plain output mode: transmit still high, so the line must show the register value
        apb(1'h1, 12'h000, 32'h10);
        repeat (2) @(posedge clk);
        chk("shr_gpio", 2'h0, {shared_io_line_oe_n, shared_io_line_out});
        // watchdog with the boot strap moved: modes must stay, registers clear
        apb(1'h1, 12'h000, 32'h3);
        board.strap(1'h1);
        wdt_reset_req <= 1'h1;
        @(posedge clk);
        wdt_reset_req <= 1'h0;
        @(posedge clk);
        wait_up();
        chk("wdt_boot", 1, boot_ext_16bit);
        rd_chk("wdt_ctrl", 12'h000, 32'hFFFFFFFF, 32'h0);
        rd_chk("wdt_st", 12'h004, 32'h21, 32'h20);
        // pin and watchdog together; float select low all ten cycles
        fork
            reset_pin(1'h1, 10);
            begin
                repeat (8) @(posedge clk);
                wdt_reset_req <= 1'h1;
                chk("addr_rst", 0, ebi_addr_out);
                chk("clk_rst", 0, periph_clk_en_out);
                @(posedge clk);
                wdt_reset_req <= 1'h0;
            end
        join
        chk("boot8", 3'h1, {boot_ext_16bit, boot_internal_nvm, boot_chip_select_en});
        chk("float", 32'hFFFFFFFF, pad_oe_n_out);
        rd_chk("fl_st", 12'h004, 32'h23, 32'h3);
        apb(1'h1, 12'h000, 32'h3);
        repeat (2) @(posedge clk);
        chk("fl_port_b_line_18", 1, port_b_line_18_oe_n);
        // nine low cycles fall one short of float mode
        reset_pin(1'h0, 9);
        chk("nofloat", pad_oe_n_in, pad_oe_n_out);
        rd_chk("nf_st", 12'h004, 32'h3, 32'h0);
        fork
            board.dbg_reset(1'h1);
            reset_pin(1'h0, 0);
        join
        chk("scan", 2'h1, {ice_enable, bscan_enable});
        chk("scan_id", SID, chip_id);
        for (int i = 0; i < 4; i++) begin
            bscan_ir <= ir_tab[i];
            @(posedge clk);
            @(posedge clk);
            chk("ir", dec_tab[i], {bscan_extest, bscan_sample, bscan_bypass});
        end
        reset_pin(1'h0, 0);
        chk("scan_kept", 1, bscan_enable);
        board.dbg_reset(1'h0);
        repeat (3) @(posedge clk);
        chk("ice_back", 2'h2, {ice_enable, bscan_enable});
        final_report();
    end
endmodule
bind rbms_reset_boot_sampler rbms_reset_boot_sampler_monitor #(.CLKEN_W(CLKEN_W), .CORE_ID(CORE_ID),
    .SCAN_ID(SCAN_ID)) mon (.*);
